// [logic/obm_bus_monitor.sv]
// Purpose: Monitor modes, header store and CAN ID filtering behind APB.
// Assumes: Messages arrive whole on msgValid; UART bytes on this clock.
// Notes: rts_n and kLineActive are pins and are synchronised.
`timescale 1ns/100ps
`default_nettype none
module obm_bus_monitor
   import obm_pkg::*;
#(
   parameter int QUIET_CYC = QUIET_CYCLES,
   parameter int KEEPALIVE_CYC = KEEPALIVE_CYCLES,
   parameter int TX_DEPTH = 256
)(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rts_n,
   input wire logic kLineActive,
   input wire logic rxValid,
   input wire logic [7:0] rxChar,
   input wire logic msgValid,
   input wire logic [28:0] msgId,
   input wire logic [3:0] msgLen,
   input wire logic [63:0] msgData,
   output logic txValid,
   input wire logic txReady,
   output logic [7:0] txData,
   output logic busy,
   output logic keepAlive,
   output logic ackEnable,
   output logic searching,
   output logic [3:0] protocol,
   output logic [28:0] requestId
);
   typedef enum logic [2:0] {S_IDLE, S_MON, S_PRINT, S_PROMPT} obm_state_t;
   obm_state_t state_q, state_d;

   logic [1:0] rtsSync_q, klSync_q;
   logic [1:0] mode_q;
   logic can11_q, auto_q, busInit_q, stop_q, ovf_q;
   logic [23:0] header_q;
   logic [28:0] filter_q, mask_q;
   logic [7:0] monAddr_q;
   logic [23:0] lineHdr_q;
   logic [63:0] lineData_q;
   logic [3:0] lineLen_q, idx_q, lineEnd;
   logic [31:0] quiet_q, kaCnt_q;
   logic idPass, fifoInReady, fifoInValid, quietHit, monActive;
   logic [7:0] fifoInData;
   logic apbAccess, apbWr, apbRd, addrHit, startMon, msgTake, msgDrop;

   // Byte of a printed line: header, data, end of line
   function automatic logic [7:0] lineByte(input logic [3:0] i, input logic c11,
         input logic [23:0] h, input logic [63:0] d, input logic [3:0] n);
      logic [3:0] hn;
      logic [3:0] di;
      hn = c11 ? 4'h2 : 4'h3;
      di = i - hn;
      if (i < hn)
         lineByte = c11 ? (i == 4'h0 ? {5'h00, h[10:8]} : h[7:0])
                        : h[23 - 8*i -: 8];
      else if (i < hn + n)
         lineByte = d[63 - 8*di -: 8];
      else
         lineByte = CHAR_CR;
   endfunction

   // Pin synchronisers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rtsSync_q <= 2'h3;
         klSync_q <= 2'h0;
      end
      else
      begin
         rtsSync_q <= {rtsSync_q[0], rts_n};
         klSync_q <= {klSync_q[0], kLineActive};
      end
   end

   // APB decode
   assign apbAccess = psel && penable && !pready;
   assign apbWr = apbAccess && pwrite;
   assign apbRd = apbAccess && !pwrite;
   assign addrHit = paddr == ADDR_CTRL || paddr == ADDR_HEADER
      || paddr == ADDR_HDR_SHORT || paddr == ADDR_FILTER || paddr == ADDR_MASK
      || paddr == ADDR_MON_ADDR || paddr == ADDR_STATUS;
   assign startMon = apbWr && paddr == ADDR_CTRL
      && pwdata[CTRL_MODE_LO +: 2] != MODE_OFF && state_q == S_IDLE;
   assign monActive = state_q == S_MON || state_q == S_PRINT;

   // APB handshake, one wait state
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= apbAccess;
         pslverr <= apbAccess && !addrHit;
         prdata <= 32'h00000000;
         if (apbRd)
         begin
            case (paddr)
               ADDR_CTRL: prdata <= {23'h000000, protocol, busInit_q, auto_q, can11_q,
                                     mode_q};
               ADDR_HEADER: prdata <= {8'h00, header_q};
               ADDR_FILTER: prdata <= {3'h0, filter_q};
               ADDR_MASK: prdata <= {3'h0, mask_q};
               ADDR_MON_ADDR: prdata <= {24'h000000, monAddr_q};
               ADDR_STATUS: prdata <= {23'h000000, protocol, searching, ovf_q,
                                       state_q == S_PRINT, monActive, busy};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         mode_q <= MODE_OFF;
         can11_q <= 1'b0;
         auto_q <= 1'b0;
         busInit_q <= 1'b0;
         header_q <= HEADER_RESET;
         filter_q <= FILTER_RESET;
         mask_q <= MASK_RESET;
         monAddr_q <= 8'h00;
      end
      else if (apbWr)
      begin
         case (paddr)
            ADDR_CTRL:
            begin
               if (state_q == S_IDLE)
                  mode_q <= pwdata[CTRL_MODE_LO +: 2];
               can11_q <= pwdata[CTRL_CAN11];
               auto_q <= pwdata[CTRL_AUTO];
               busInit_q <= pwdata[CTRL_BUSINIT];
            end
            ADDR_HEADER: header_q <= pwdata[23:0];
            ADDR_HDR_SHORT: header_q <= {12'h000, pwdata[11:0]};
            ADDR_FILTER: filter_q <= pwdata[28:0];
            ADDR_MASK: mask_q <= pwdata[28:0];
            ADDR_MON_ADDR: monAddr_q <= pwdata[7:0];
            default: mode_q <= mode_q;
         endcase
      end
   end

   // Request identifier from the header store
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         requestId <= 29'h00000000;
      else
         requestId <= can11_q ? {18'h00000, header_q[10:0]}
                              : {PRIO_RESET, header_q};
   end

   obm_id_filter u_filter (
      .rxId(msgId),
      .can11(can11_q),
      .filterVal(filter_q),
      .maskVal(mask_q),
      .mode(mode_q),
      .monAddr(monAddr_q),
      .pass(idPass)
   );

   // Message acceptance; busy printing drops a new message
   assign msgTake = state_q == S_MON && msgValid && idPass && !stop_q;
   assign msgDrop = state_q == S_PRINT && msgValid && idPass;
   assign lineEnd = (can11_q ? 4'h2 : 4'h3) + lineLen_q;

   // Stop request; the character itself is never stored
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         stop_q <= 1'b0;
      else if (monActive && (!rtsSync_q[1] || rxValid))
         stop_q <= 1'b1;
      else if (state_q == S_PROMPT || state_q == S_IDLE)
         stop_q <= 1'b0;
   end

   // Monitor state machine
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         S_IDLE:
            if (startMon)
               state_d = S_MON;
         S_MON:
            if (stop_q)
               state_d = S_PROMPT;
            else if (msgTake)
               state_d = S_PRINT;
         S_PRINT:
            if (fifoInReady && idx_q == lineEnd)
               state_d = stop_q ? S_PROMPT : S_MON;
         S_PROMPT:
            if (fifoInReady)
               state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_q <= S_IDLE;
         busy <= 1'b0;
         ackEnable <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         busy <= state_d != S_IDLE;
         ackEnable <= state_d != S_MON && state_d != S_PRINT;
      end
   end

   // Line capture and byte index
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         lineHdr_q <= 24'h000000;
         lineData_q <= 64'h0000000000000000;
         lineLen_q <= 4'h0;
         idx_q <= 4'h0;
      end
      else if (msgTake)
      begin
         lineHdr_q <= msgId[23:0];
         lineData_q <= msgData;
         lineLen_q <= msgLen > 4'h8 ? 4'h8 : msgLen;
         idx_q <= 4'h0;
      end
      else if (state_q == S_PRINT && fifoInReady)
         idx_q <= idx_q + 4'h1;
   end

   // Bytes into the transmit queue
   assign fifoInValid = state_q == S_PRINT || state_q == S_PROMPT;
   assign fifoInData = state_q == S_PROMPT ? CHAR_PROMPT
      : lineByte(idx_q, can11_q, lineHdr_q, lineData_q, lineLen_q);

   obm_tx_fifo #(
      .WIDTH(8),
      .DEPTH(TX_DEPTH)
   ) u_txq (
      .clock(clock),
      .rst_n(rst_n),
      .inValid(fifoInValid),
      .inData(fifoInData),
      .inReady(fifoInReady),
      .outValid(txValid),
      .outReady(txReady),
      .outData(txData)
   );

   // Overflow: a message lost to a busy output; write 1 clears, set wins
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         ovf_q <= 1'b0;
      else if (msgDrop)
         ovf_q <= 1'b1;
      else if (apbWr && paddr == ADDR_STATUS && pwdata[STAT_OVF])
         ovf_q <= 1'b0;
   end

   // Silent bus timer and protocol search
   assign quietHit = quiet_q >= 32'(QUIET_CYC - 1);
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         quiet_q <= 32'h00000000;
         searching <= 1'b0;
         protocol <= PROTO_RESET;
      end
      else
      begin
         if (state_q != S_MON || msgValid || quietHit)
            quiet_q <= 32'h00000000;
         else
            quiet_q <= quiet_q + 32'h00000001;
         if (apbWr && paddr == ADDR_CTRL)
            protocol <= pwdata[CTRL_PROTO_LO +: 4];
         if (!monActive || msgValid)
            searching <= 1'b0;
         else if (searching && klSync_q[1])
         begin
            searching <= 1'b0;
            protocol <= PROTO_ISO9141;
         end
         else if (quietHit && auto_q)
         begin
            searching <= 1'b1;
            protocol <= (protocol >= PROTO_LAST || protocol < PROTO_FIRST)
               ? PROTO_FIRST : protocol + 4'h1;
         end
      end
   end

   // Keep-alive timer, held off while monitoring
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         kaCnt_q <= 32'h00000000;
         keepAlive <= 1'b0;
      end
      else
      begin
         keepAlive <= 1'b0;
         if (!busInit_q || monActive || state_d == S_MON)
            kaCnt_q <= 32'h00000000;
         else if (kaCnt_q >= 32'(KEEPALIVE_CYC - 1))
         begin
            kaCnt_q <= 32'h00000000;
            keepAlive <= 1'b1;
         end
         else
            kaCnt_q <= kaCnt_q + 32'h00000001;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_stopReq;
      monActive && (!rtsSync_q[1] || rxValid);
   endsequence
   sequence s_promptOut;
      state_q == S_PROMPT && fifoInReady;
   endsequence

   a_stop_latch: assert property (s_stopReq |=> stop_q)
      else $error("stop request not latched");
   a_mon_exit: assert property (state_q == S_MON && stop_q |=> state_q == S_PROMPT)
      else $error("monitor did not stop");
   a_line_finish: assert property (state_q == S_PRINT && stop_q && !fifoInReady
      |=> state_q == S_PRINT)
      else $error("line abandoned on stop");
   a_prompt_idle: assert property (s_promptOut |=> state_q == S_IDLE && !busy)
      else $error("prompt not followed by idle");
   a_quiet_ack: assert property (monActive |-> !ackEnable)
      else $error("ack enabled while monitoring");
   a_no_keepalive: assert property (monActive |=> !keepAlive)
      else $error("keep-alive during monitor");
   a_short_pad: assert property (apbWr && paddr == ADDR_HDR_SHORT
      |=> header_q == {12'h000, $past(pwdata[11:0])})
      else $error("short header not padded");
   a_filter_block: assert property (state_q == S_MON && msgValid && !idPass && !stop_q
      |=> state_q == S_MON)
      else $error("filtered message printed");
   a_ovf_set: assert property (msgDrop |=> ovf_q)
      else $error("overflow not flagged");
   a_search_9141: assert property (monActive && searching && klSync_q[1] && !msgValid
      |=> protocol == PROTO_ISO9141 && !searching)
      else $error("search did not settle");
   a_req_id11: assert property (can11_q |=> requestId[28:11] == 18'h00000
      || $changed(can11_q))
      else $error("11-bit id has high bits");
endmodule
`default_nettype wire

// [logic/obm_pkg.sv]
// Purpose: Shared constants for the bus monitor and header/filter block.
// Assumes: 125 MHz clock, APB register access, 32-bit data.
// Notes: Byte offsets are APB byte addresses.
package obm_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_HEADER = 8'h04;
   localparam logic [7:0] ADDR_HDR_SHORT = 8'h08;
   localparam logic [7:0] ADDR_FILTER = 8'h0C;
   localparam logic [7:0] ADDR_MASK = 8'h10;
   localparam logic [7:0] ADDR_MON_ADDR = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // Control field positions
   localparam int CTRL_MODE_LO = 0;
   localparam int CTRL_CAN11 = 2;
   localparam int CTRL_AUTO = 3;
   localparam int CTRL_BUSINIT = 4;
   localparam int CTRL_PROTO_LO = 5;
   // Status field positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_MON = 1;
   localparam int STAT_PRINT = 2;
   localparam int STAT_OVF = 3;
   localparam int STAT_SEARCH = 4;
   localparam int STAT_PROTO_LO = 5;
   // Monitor modes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_ALL = 2'h1;
   localparam logic [1:0] MODE_RCV = 2'h2;
   localparam logic [1:0] MODE_XMT = 2'h3;
   // Protocol codes
   localparam logic [3:0] PROTO_RESET = 4'h0;
   localparam logic [3:0] PROTO_FIRST = 4'h1;
   localparam logic [3:0] PROTO_ISO9141 = 4'h3;
   localparam logic [3:0] PROTO_LAST = 4'h9;
   // Reset values
   localparam logic [23:0] HEADER_RESET = 24'h000000;
   localparam logic [28:0] FILTER_RESET = 29'h00000000;
   localparam logic [28:0] MASK_RESET = 29'h00000000;
   localparam logic [4:0] PRIO_RESET = 5'h1B;
   // Printed characters
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_PROMPT = 8'h3E;
   // Timing
   localparam int CLK_MHZ = 125;
   localparam int QUIET_US = 100000;
   localparam int QUIET_CYCLES = QUIET_US * CLK_MHZ;
   localparam int KEEPALIVE_MS = 3000;
   localparam int KEEPALIVE_CYCLES = KEEPALIVE_MS * 1000 * CLK_MHZ;
endpackage

// [logic/obm_id_filter.sv]
// Purpose: Decide whether a received identifier is passed to the output.
// Assumes: Header store layout with 11-bit IDs in the low bits.
// Notes: Purely combinational; the caller uses the result unregistered.
`timescale 1ns/100ps
`default_nettype none
module obm_id_filter
   import obm_pkg::*;
(
   input wire logic [28:0] rxId,
   input wire logic can11,
   input wire logic [28:0] filterVal,
   input wire logic [28:0] maskVal,
   input wire logic [1:0] mode,
   input wire logic [7:0] monAddr,
   output logic pass
);
   logic [28:0] effMask;
   logic idOk;
   logic addrOk;

   // Mask limited to 11 bits on short IDs; mask 1 bits must match
   assign effMask = can11 ? {18'h00000, maskVal[10:0]} : maskVal;
   assign idOk = ((rxId ^ filterVal) & effMask) == 29'h00000000;

   // Address match per monitor mode
   always_comb
   begin
      case (mode)
         MODE_ALL: addrOk = 1'b1;
         MODE_RCV: addrOk = can11 ? (rxId[10:8] == monAddr[2:0])
                                  : (rxId[15:8] == monAddr);
         MODE_XMT: addrOk = rxId[7:0] == monAddr;
         default: addrOk = 1'b0;
      endcase
   end

   assign pass = idOk && addrOk;
endmodule
`default_nettype wire

// [logic/obm_tx_fifo.sv]
// Purpose: Transmit byte queue towards the serial link.
// Assumes: Drain side may stall; full stalls the filling side.
// Notes: Output stage is a register, one byte beyond the array depth.
`timescale 1ns/100ps
`default_nettype none
module obm_tx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256
)(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   assign inReady = count_q != (AW+1)'(DEPTH);
   assign push = inValid && inReady;
   assign pop = (count_q != '0) && (!outValid || outReady);

   // Storage array
   always_ff @(posedge clock)
   begin
      if (push)
         mem[wrPtr_q] <= inData;
   end

   // Pointers and fill level
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wrPtr_q <= wrPtr_q + 1'b1;
         if (pop)
            rdPtr_q <= rdPtr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end

   // Registered output stage
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         outValid <= 1'b0;
         outData <= '0;
      end
      else if (pop)
      begin
         outValid <= 1'b1;
         outData <= mem[rdPtr_q];
      end
      else if (outReady)
         outValid <= 1'b0;
   end
endmodule
`default_nettype wire

// [tb/obm_link_model.sv]
// Purpose: Serial sink and vehicle message source for the bench.
// Assumes: One clock; a byte is taken when txValid and txReady meet.
// Notes: Released message lines show inverted data.
`timescale 1ns/100ps
`default_nettype none
module obm_link_model
(
   input wire logic clock,
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   output logic msgValid,
   output logic [28:0] msgId,
   output logic [3:0] msgLen,
   output logic [63:0] msgData
);
   logic slow = 1'h0;
   logic [1:0] ph = 2'h0;
   logic [7:0] got[$];
   // Collect bytes; a slow link is ready one cycle in four
   always @(posedge clock)
   begin
      if (txValid === 1'h1 && txReady === 1'h1)
         got.push_back(txData);
      ph <= ph + 2'h1;
      txReady <= !slow || ph == 2'h3;
   end
   // One-byte message from an ECU with the given id, valid for one cycle, then released for one
   task automatic send(input logic [28:0] id, input logic [63:0] d);
      msgValid <= 1'h1;
      msgId <= id;
      msgData <= d;
      @(posedge clock);
      msgValid <= 1'h0;
      msgId <= ~id;
      msgData <= ~d;
      @(posedge clock);
   endtask
   // Idle levels at start
   initial
   begin
      txReady = 1'h1;
      msgValid = 1'h0;
      msgId = 29'h0;
      msgLen = 4'h1;
      msgData = 64'h0;
   end
endmodule
`default_nettype wire

// [tb/test_obd_bus_monitor_filter.sv]
// Purpose: Self-checking bench for the bus monitor and ID filter.
// Assumes: Short quiet and keep-alive counts for simulation.
// Notes: Link partner collects serial bytes and injects traffic.
`timescale 1ns/100ps
`default_nettype none
module test_obd_bus_monitor_filter
   import obm_pkg::*;
;
   logic clock, pready, pslverr, rdErr, txValid, txReady, busy;
   logic keepAlive, ackEnable, searching, msgValid;
   logic rst_n = 1'h0, rts_n = 1'h1, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, rxValid = 1'h0, kLineActive = 1'h0;
   logic [7:0] paddr = 8'h0, rxChar = 8'h0, txData;
   logic [31:0] pwdata = 32'h0, prdata, rdData;
   logic [28:0] msgId, requestId;
   logic [3:0] msgLen, protocol;
   logic [63:0] msgData;
   logic [7:0] expLine[$];
   int failCount = 0, comparisons = 0, cycles = 0, kaCount = 0, kaBase;

   // Two-deep queue so a slow link stalls a line while it prints
   obm_bus_monitor #(.QUIET_CYC(50), .KEEPALIVE_CYC(40), .TX_DEPTH(2)) DUT (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rts_n(rts_n),
      .kLineActive(kLineActive), .rxValid(rxValid), .rxChar(rxChar),
      .msgValid(msgValid), .msgId(msgId), .msgLen(msgLen),
      .msgData(msgData), .txValid(txValid), .txReady(txReady),
      .txData(txData), .busy(busy), .keepAlive(keepAlive),
      .ackEnable(ackEnable), .searching(searching), .protocol(protocol),
      .requestId(requestId));
   obm_link_model link (
      .clock(clock), .txValid(txValid), .txData(txData), .txReady(txReady),
      .msgValid(msgValid), .msgId(msgId), .msgLen(msgLen), .msgData(msgData));

   // Clock, 8 ns period
   initial
   begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end
   // Cycle limit and keep-alive pulse count
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (keepAlive === 1'h1)
         kaCount <= kaCount + 1;
      if (cycles == 20000)
      begin
         failCount++;
         testDone();
      end
   end

   task automatic testDone;
      $display("checks %0d, mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // APB transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      @(posedge clock);
      while (pready !== 1'h1)
         @(posedge clock);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rdData, e);
   endtask
   // Wait for the expected serial bytes, then compare them
   task automatic line;
      while (link.got.size() < expLine.size())
         @(posedge clock);
      foreach (expLine[i])
         chk({24'h0, link.got[i]}, {24'h0, expLine[i]});
      link.got.delete();
   endtask
   task automatic stopChar;
      rxValid <= 1'h1;
      rxChar <= 8'h31;
      @(posedge clock);
      rxValid <= 1'h0;
      rxChar <= 8'hCE;
   endtask

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clock);
      rst_n <= 1'h1;
      repeat (2) @(posedge clock);
      rd(ADDR_HEADER, 32'h0);
      apb(1'h0, 8'h40, 32'h0);
      chk({31'h0, rdErr}, 32'h1);
      apb(1'h1, ADDR_CTRL, 32'h4);
      apb(1'h1, ADDR_HDR_SHORT, 32'h7DF);
      rd(ADDR_HEADER, 32'h7DF);
      apb(1'h1, ADDR_HDR_SHORT, 32'h7E0);
      chk({3'h0, requestId}, 32'h7E0);
      apb(1'h1, ADDR_HEADER, 32'hFFFFFF);
      chk({3'h0, requestId}, 32'h7FF);
      // Monitor all on 29-bit ids, keep-alive held off
      apb(1'h1, ADDR_CTRL, 32'h10);
      repeat (100) @(posedge clock);
      chk({31'h0, kaCount != 0}, 32'h1);
      apb(1'h1, ADDR_CTRL, 32'h11);
      kaBase = kaCount;
      rd(ADDR_STATUS, 32'h3);
      chk({31'h0, ackEnable}, 32'h0);
      link.send(29'h18DAF110, 64'h4100000000000000);
      // Arrives while the first line prints: dropped, overflow flagged
      link.send(29'h18DAF118, 64'h4100000000000000);
      expLine = '{8'hDA, 8'hF1, 8'h10, 8'h41, 8'h0D};
      line();
      repeat (100) @(posedge clock);
      chk(kaCount - kaBase, 32'h0);
      stopChar();
      expLine = '{8'h3E};
      line();
      chk({31'h0, busy}, 32'h0);
      chk({31'h0, ackEnable}, 32'h1);
      rd(ADDR_STATUS, 32'h8);
      apb(1'h1, ADDR_STATUS, 32'h8);
      rd(ADDR_STATUS, 32'h0);
      // Transmitter match, 11-bit, stop by RTS
      apb(1'h1, ADDR_MON_ADDR, 32'h10);
      apb(1'h1, ADDR_CTRL, 32'h7);
      link.send(29'h711, 64'h5500000000000000);
      link.send(29'h710, 64'h5500000000000000);
      expLine = '{8'h07, 8'h10, 8'h55, 8'h0D, 8'h3E};
      rts_n <= 1'h0;
      line();
      rts_n <= 1'h1;
      repeat (4) @(posedge clock);
      // Receiver match uses low 3 address bits
      apb(1'h1, ADDR_MON_ADDR, 32'h12);
      apb(1'h1, ADDR_CTRL, 32'h6);
      link.send(29'h3AB, 64'h5500000000000000);
      link.send(29'h2AB, 64'h5500000000000000);
      expLine = '{8'h02, 8'hAB, 8'h55, 8'h0D};
      line();
      stopChar();
      expLine = '{8'h3E};
      line();
      // Filter and mask, then a stop while a slow line prints
      apb(1'h1, ADDR_FILTER, 32'h600);
      apb(1'h1, ADDR_MASK, 32'h700);
      apb(1'h1, ADDR_CTRL, 32'h5);
      link.send(29'h7AB, 64'h5500000000000000);
      link.slow = 1'h1;
      link.send(29'h6AB, 64'h5500000000000000);
      stopChar();
      expLine = '{8'h06, 8'hAB, 8'h55, 8'h0D, 8'h3E};
      line();
      link.slow = 1'h0;
      // Silent bus with auto search, K-line traffic settles it
      apb(1'h1, ADDR_CTRL, 32'hD);
      repeat (80) @(posedge clock);
      chk({31'h0, searching}, 32'h1);
      kLineActive <= 1'h1;
      repeat (8) @(posedge clock);
      chk({27'h0, searching, protocol}, {28'h0, PROTO_ISO9141});
      kLineActive <= 1'h0;
      stopChar();
      expLine = '{8'h3E};
      line();
      testDone();
   end
endmodule
`default_nettype wire
